//--- common/rgs_pkg.sv
// Constants, register map and types for the receiver gain, squelch and strength block
package rgs_pkg;
  // Gain step ladder
  localparam int STEP_W = 4;
  localparam logic [3:0] STEP_MAX = 4'ha;
  localparam logic [3:0] WIN_STEPS = 4'h4;
  localparam logic [2:0] WIN_MAX = 3'h4;
  localparam logic [2:0] PEER_G23_RED = 3'h2;
  localparam logic [3:0] AGC_PRESET_CODE = 4'h4;
  localparam logic [3:0] AGC_RESET_CODE = 4'h0;
  localparam logic [3:0] SQ_TRANS_LIMIT = 4'h2;
  localparam logic [3:0] AGC_PULSE_LIMIT = 4'h8;
  localparam logic [3:0] STR_MAX = 4'hd;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SQ_WIN_NS = 50000;
  localparam int SQ_DELAY_NS = 18880;
  localparam int SQ_WIN_CYC = (SQ_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SQ_DELAY_CYC = (SQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_RX_CFG2 = 8'h00;
  localparam logic [7:0] OFS_RX_CFG3 = 8'h04;
  localparam logic [7:0] OFS_RX_CFG4 = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_GAIN_STATE = 8'h14;
  localparam logic [7:0] OFS_STRENGTH = 8'h18;
  // Field positions
  localparam int CFG2_AGC_EN = 0;
  localparam int CFG2_AGC_M = 1;
  localparam int CFG2_AGC_ALG = 2;
  localparam int CFG2_SQM_DYN = 3;
  localparam int CFG3_CLIP_EN = 0;
  localparam int CFG3_GAIN_CUT = 1;
  localparam int CMD_GAIN_RELOAD = 0;
  localparam int CMD_SQUELCH = 1;
  localparam int CMD_STR_CLEAR = 2;
  localparam int CMD_ANALOG_PRESET = 3;
  localparam int GST_LIVE_LSB = 4;
  localparam int GST_SQ_BUSY = 8;
  localparam int STR_B_LSB = 4;
  // Reset values
  localparam logic [3:0] CFG2_RST = 4'h5;
  localparam logic [1:0] CFG3_RST = 2'h0;
  localparam logic [3:0] CFG4_RST = 4'h0;
  // Squelch sequencer states, Gray along idle, delay, run
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_DELAY = 2'b01,
    SQ_RUN = 2'b11
  } rgs_sq_state_t;
endpackage : rgs_pkg

//--- common/rgs_trans_if.sv
// Carrier between the top and a comparator transition counter
`timescale 1ns/1ps
interface rgs_trans_if;
  logic clr;
  logic din;
  logic [3:0] cnt;
  modport cnt_side (input clr, input din, output cnt);
  modport user (output clr, output din, input cnt);
endinterface : rgs_trans_if

//--- hw/rgs_trans_cnt.sv
// Saturating counter of transitions on a synchronised comparator output
`timescale 1ns/1ps
module rgs_trans_cnt #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Counter carrier
  rgs_trans_if.cnt_side p
);
  logic prev_r;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire edge_seen = p.din ^ prev_r;
  wire cnt_full = &cnt_r;

  // Next count: clear wins, otherwise count edges and stop at all ones
  assign cnt_nxt = p.clr ? '0 : ((edge_seen && !cnt_full) ? cnt_r + 1'b1 : cnt_r);
  assign p.cnt = cnt_r;

  // Edge history and count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_r <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      prev_r <= p.din;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : rgs_trans_cnt

//--- hw/rgs_peak_hold.sv
// Peak-hold strength meter for one demodulation channel
`timescale 1ns/1ps
module rgs_peak_hold #(
  parameter int W = 4,
  parameter logic [3:0] MAX = rgs_pkg::STR_MAX
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic en,
  // Level in, held peak out
  input wire logic [W-1:0] lvl,
  output logic [W-1:0] peak
);
  logic [W-1:0] peak_r;
  wire [W-1:0] lvl_sat = (lvl > W'(MAX)) ? W'(MAX) : lvl;

  assign peak = peak_r;

  // Clear wins and zeros it; otherwise only rises while enabled, frozen when not
  always_ff @(posedge clk)
  begin
    if (!rst_n || clr)
      peak_r <= '0;
    else if (en && (lvl_sat > peak_r))
      peak_r <= lvl_sat;
  end
endmodule : rgs_peak_hold

//--- hw/rgs_top.sv
// Receiver gain-reduction control: squelch, automatic gain loop, strength meter
// Operation
// - Eleven steps: four widen digitizer window, six more cut stage gain.
// - Squelch starts from the configured initial step; the gain loop starts from its start code.
// - Gain state register shows the effective step in use.
// - Squelch raises one step per 50 us window with over two transitions.
// - Gain reload command clears squelch-accumulated reduction.
// - Gain reload resets loop, squelch, meter and loads the initial step.
// - Dynamic squelch starts 18.88 us after transmit end, stops at mask expiry.
// - Squelch command is taken only while the receive window is low.
// - Gain loop starts on receive window rise, stops on its fall and holds its step.
// - Receive window fall stores the current step for software.
// - Gain loop raises reduction while the wide comparator toggles.
// - Duration bit: whole window or first eight subcarrier pulses.
// - Start bit: gain loop begins at code 4h or code 0h.
// - Reset: gain loop on, whole window, preset start code.
// - Meter runs while receive window high, frozen while low.
// - Meter holds peak from zero, restarts when the loop raises reduction.
// - Strength is four bits per channel, largest code Dh.
// - Strength clear command zeros and restarts the meter.
// - Peer gain cut forces stage cut 6 dB and widest window.
// - Analog preset in peer mode sets clipping and peer gain cut.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module rgs_top #(
  parameter int SQ_WIN_CYC = rgs_pkg::SQ_WIN_CYC,
  parameter int SQ_DELAY_CYC = rgs_pkg::SQ_DELAY_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Comparator pins
  input wire logic DIG_CMP,
  input wire logic AGC_CMP,
  // Receive framing events
  input wire logic RX_ON,
  input wire logic TX_END,
  input wire logic MASK_RX_DONE,
  input wire logic SUBC_PULSE,
  // Channel strength levels
  input wire logic [3:0] STR_LVL_A,
  input wire logic [3:0] STR_LVL_B,
  // Analog gain controls
  output logic [2:0] DIG_WIN,
  output logic [2:0] GAIN23_RED,
  output logic CLIP_EN
);
  localparam int TW = 16;

  // Comparator synchronisers
  logic dig_s1_r, dig_s2_r, agc_s1_r, agc_s2_r;
  always_ff @(posedge SYS_CLK)
  begin
    dig_s1_r <= DIG_CMP;
    dig_s2_r <= dig_s1_r;
    agc_s1_r <= AGC_CMP;
    agc_s2_r <= agc_s1_r;
  end

  // Bus state
  logic wr_pend_r, rd_pend_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic [3:0] cfg2_r;
  logic [1:0] cfg3_r;
  logic [3:0] cfg4_r;
  logic peer_mode_r;
  logic [3:0] gain_state_r;
  logic [3:0] eff_step_r;
  logic [3:0] str_a, str_b;
  rgs_pkg::rgs_sq_state_t sq_state_r;

  // Address phase decode and register selects
  wire ahb_go = HSEL && HTRANS[1] && HREADY;
  wire sel_cfg2 = addr_r == rgs_pkg::OFS_RX_CFG2;
  wire sel_cfg3 = addr_r == rgs_pkg::OFS_RX_CFG3;
  wire sel_cfg4 = addr_r == rgs_pkg::OFS_RX_CFG4;
  wire sel_mode = addr_r == rgs_pkg::OFS_MODE;
  wire sel_cmd = addr_r == rgs_pkg::OFS_CMD;
  wire sel_gst = addr_r == rgs_pkg::OFS_GAIN_STATE;
  wire sel_str = addr_r == rgs_pkg::OFS_STRENGTH;
  wire cmd_wr = wr_pend_r && sel_cmd;
  wire cmd_reload = cmd_wr && HWDATA[rgs_pkg::CMD_GAIN_RELOAD];
  wire cmd_squelch = cmd_wr && HWDATA[rgs_pkg::CMD_SQUELCH];
  wire cmd_str_clr = cmd_wr && HWDATA[rgs_pkg::CMD_STR_CLEAR];
  wire cmd_preset = cmd_wr && HWDATA[rgs_pkg::CMD_ANALOG_PRESET];

  // Read mux; unmapped addresses read zero
  wire sq_busy = sq_state_r != rgs_pkg::SQ_IDLE;
  wire [31:0] gst_word = {23'h0, sq_busy, eff_step_r, gain_state_r};
  wire [31:0] rd_mux =
    sel_cfg2 ? {28'h0, cfg2_r} :
    sel_cfg3 ? {30'h0, cfg3_r} :
    sel_cfg4 ? {28'h0, cfg4_r} :
    sel_mode ? {31'h0, peer_mode_r} :
    sel_gst ? gst_word :
    sel_str ? {24'h0, str_b, str_a} : 32'h0;

  assign HRDATA = hrdata_r;
  assign HREADYOUT = !rd_pend_r;
  assign HRESP = 1'b0;

  // Bus phases: writes zero-wait, reads take one wait state
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end
    else
    begin
      wr_pend_r <= ahb_go && HWRITE;
      rd_pend_r <= ahb_go && !HWRITE;
      if (ahb_go)
        addr_r <= HADDR[7:0];
      if (rd_pend_r)
        hrdata_r <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      cfg2_r <= rgs_pkg::CFG2_RST;
      cfg3_r <= rgs_pkg::CFG3_RST;
      cfg4_r <= rgs_pkg::CFG4_RST;
      peer_mode_r <= 1'b0;
    end
    else
    begin
      if (wr_pend_r && sel_cfg2)
        cfg2_r <= HWDATA[3:0];
      if (cmd_preset && peer_mode_r)
        cfg3_r <= 2'h3;
      else if (wr_pend_r && sel_cfg3)
        cfg3_r <= HWDATA[1:0];
      if (wr_pend_r && sel_cfg4)
        cfg4_r <= (HWDATA[3:0] > rgs_pkg::STEP_MAX) ? rgs_pkg::STEP_MAX : HWDATA[3:0];
      if (wr_pend_r && sel_mode)
        peer_mode_r <= HWDATA[0];
    end
  end

  wire agc_en = cfg2_r[rgs_pkg::CFG2_AGC_EN];
  wire agc_m = cfg2_r[rgs_pkg::CFG2_AGC_M];
  wire agc_alg = cfg2_r[rgs_pkg::CFG2_AGC_ALG];
  wire sqm_dyn = cfg2_r[rgs_pkg::CFG2_SQM_DYN];
  wire gain_cut = cfg3_r[rgs_pkg::CFG3_GAIN_CUT];

  // Transition counters on both comparators
  rgs_trans_if dig_if ();
  rgs_trans_if agc_if ();
  rgs_trans_cnt #(.W(4)) u_dig_cnt (.clk(SYS_CLK), .rst_n(RST_N), .p(dig_if));
  rgs_trans_cnt #(.W(4)) u_agc_cnt (.clk(SYS_CLK), .rst_n(RST_N), .p(agc_if));

  // Receive window edges
  logic rx_d_r;
  wire rx_rise = RX_ON && !rx_d_r;
  wire rx_fall = !RX_ON && rx_d_r;

  // Squelch sequencer
  logic [TW-1:0] sq_cnt_r;
  logic [3:0] sq_step_r;
  logic sq_dyn_r;
  rgs_pkg::rgs_sq_state_t sq_state_nxt;
  wire sq_cmd_ok = cmd_squelch && !RX_ON;
  wire sq_dyn_go = TX_END && sqm_dyn;
  wire sq_delay_end = sq_cnt_r == TW'(SQ_DELAY_CYC - 1);
  wire sq_win_end = (sq_state_r == rgs_pkg::SQ_RUN) && (sq_cnt_r == TW'(SQ_WIN_CYC - 1));
  wire sq_noisy = dig_if.cnt > rgs_pkg::SQ_TRANS_LIMIT;
  wire sq_at_max = sq_step_r >= rgs_pkg::STEP_MAX;
  wire sq_raise = sq_win_end && sq_noisy && !sq_at_max;
  wire sq_mask_stop = MASK_RX_DONE && sq_dyn_r;

  // Window restart: counting only inside a running window
  assign dig_if.din = dig_s2_r;
  assign dig_if.clr = (sq_state_r != rgs_pkg::SQ_RUN) || sq_win_end;

  // Squelch next state
  always_comb
  begin
    sq_state_nxt = sq_state_r;
    case (sq_state_r)
      rgs_pkg::SQ_IDLE:
      begin
        if (sq_cmd_ok)
          sq_state_nxt = rgs_pkg::SQ_RUN;
        else if (sq_dyn_go)
          sq_state_nxt = rgs_pkg::SQ_DELAY;
      end
      rgs_pkg::SQ_DELAY:
      begin
        if (sq_mask_stop)
          sq_state_nxt = rgs_pkg::SQ_IDLE;
        else if (sq_delay_end)
          sq_state_nxt = rgs_pkg::SQ_RUN;
      end
      rgs_pkg::SQ_RUN:
      begin
        if (sq_mask_stop || (sq_win_end && !sq_raise))
          sq_state_nxt = rgs_pkg::SQ_IDLE;
      end
      default: sq_state_nxt = rgs_pkg::SQ_IDLE;
    endcase
    if (cmd_reload)
      sq_state_nxt = rgs_pkg::SQ_IDLE;
  end

  // Squelch registers
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      sq_state_r <= rgs_pkg::SQ_IDLE;
      sq_cnt_r <= '0;
      sq_step_r <= rgs_pkg::CFG4_RST;
      sq_dyn_r <= 1'b0;
    end
    else
    begin
      sq_state_r <= sq_state_nxt;
      if (sq_state_nxt != sq_state_r || sq_win_end)
        sq_cnt_r <= '0;
      else
        sq_cnt_r <= sq_cnt_r + 1'b1;
      if (sq_state_r == rgs_pkg::SQ_IDLE)
        sq_dyn_r <= sq_dyn_go && !sq_cmd_ok;
      if (cmd_reload)
        sq_step_r <= cfg4_r;
      else if (sq_raise)
        sq_step_r <= sq_step_r + 1'b1;
    end
  end

  // Gain loop
  logic [3:0] agc_step_r;
  logic [3:0] pulse_cnt_r;
  wire agc_in_time = !agc_m || (pulse_cnt_r < rgs_pkg::AGC_PULSE_LIMIT);
  wire agc_active = RX_ON && agc_en && !rx_rise && agc_in_time;
  wire agc_raise = agc_active && (agc_if.cnt != 4'h0)
    && (agc_step_r < rgs_pkg::STEP_MAX);
  wire [3:0] agc_start = agc_alg ? rgs_pkg::AGC_PRESET_CODE : rgs_pkg::AGC_RESET_CODE;

  assign agc_if.din = agc_s2_r;
  assign agc_if.clr = !agc_active || agc_raise;

  // Gain loop registers; the step holds outside the window until a reload, and the squelch step applies there
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rx_d_r <= 1'b0;
      agc_step_r <= rgs_pkg::CFG4_RST;
      pulse_cnt_r <= 4'h0;
    end
    else
    begin
      rx_d_r <= RX_ON;
      if (rx_rise)
        pulse_cnt_r <= 4'h0;
      else if (SUBC_PULSE && pulse_cnt_r < rgs_pkg::AGC_PULSE_LIMIT)
        pulse_cnt_r <= pulse_cnt_r + 1'b1;
      if (cmd_reload)
        agc_step_r <= cfg4_r;
      else if (rx_rise)
        agc_step_r <= agc_start;
      else if (agc_raise)
        agc_step_r <= agc_step_r + 1'b1;
    end
  end

  // Effective step and its analog decode
  wire agc_owns = RX_ON && agc_en && !rx_rise;
  wire [3:0] eff_nxt = agc_owns ? agc_step_r : sq_step_r;
  wire in_win_part = eff_step_r <= rgs_pkg::WIN_STEPS;
  wire [2:0] win_dec = in_win_part ? eff_step_r[2:0] : rgs_pkg::WIN_MAX;
  wire [3:0] g23_diff = eff_step_r - rgs_pkg::WIN_STEPS;
  wire [2:0] g23_dec = in_win_part ? 3'h0 : g23_diff[2:0];

  // Output and gain state registers
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      eff_step_r <= rgs_pkg::CFG4_RST;
      gain_state_r <= rgs_pkg::CFG4_RST;
      DIG_WIN <= 3'h0;
      GAIN23_RED <= 3'h0;
      CLIP_EN <= 1'b0;
    end
    else
    begin
      eff_step_r <= eff_nxt;
      if (rx_fall)
        gain_state_r <= eff_step_r;
      DIG_WIN <= gain_cut ? rgs_pkg::WIN_MAX : win_dec;
      GAIN23_RED <= gain_cut ? rgs_pkg::PEER_G23_RED : g23_dec;
      CLIP_EN <= cfg3_r[rgs_pkg::CFG3_CLIP_EN];
    end
  end

  // Strength meters for both channels
  wire str_clr = cmd_str_clr || cmd_reload || agc_raise || rx_rise;
  wire str_en = RX_ON && !rx_rise;
  rgs_peak_hold #(.W(4), .MAX(rgs_pkg::STR_MAX)) u_str_a (
    .clk(SYS_CLK), .rst_n(RST_N), .clr(str_clr), .en(str_en), .lvl(STR_LVL_A), .peak(str_a)
  );
  rgs_peak_hold #(.W(4), .MAX(rgs_pkg::STR_MAX)) u_str_b (
    .clk(SYS_CLK), .rst_n(RST_N), .clr(str_clr), .en(str_en), .lvl(STR_LVL_B), .peak(str_b)
  );

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  property p_step_sat;
    eff_step_r <= rgs_pkg::STEP_MAX && sq_step_r <= rgs_pkg::STEP_MAX;
  endproperty
  a_step_sat: assert property (p_step_sat) else $error("gain step beyond last");

  property p_peer_cut;
    gain_cut && $stable(gain_cut) |=> DIG_WIN == 3'h4 && GAIN23_RED == 3'h2;
  endproperty
  a_peer_cut: assert property (p_peer_cut) else $error("peer gain cut not applied");

  property p_store_fall;
    rx_fall |=> gain_state_r == $past(eff_step_r);
  endproperty
  a_store_fall: assert property (p_store_fall) else $error("step not stored at fall");

  property p_reload;
    cmd_reload |=> sq_step_r == $past(cfg4_r) && sq_state_r == rgs_pkg::SQ_IDLE;
  endproperty
  a_reload: assert property (p_reload) else $error("reload did not restore step");

  property p_sq_refused;
    cmd_squelch && RX_ON && sq_state_r == rgs_pkg::SQ_IDLE && !TX_END
      |=> sq_state_r == rgs_pkg::SQ_IDLE;
  endproperty
  a_sq_refused: assert property (p_sq_refused) else $error("squelch taken in window");

  property p_str_max;
    str_a <= 4'hd && str_b <= 4'hd;
  endproperty
  a_str_max: assert property (p_str_max) else $error("strength above Dh");

  property p_str_clr;
    cmd_str_clr |=> str_a == 4'h0 && str_b == 4'h0;
  endproperty
  a_str_clr: assert property (p_str_clr) else $error("strength not cleared");

  property p_str_frozen;
    !RX_ON && !cmd_str_clr && !cmd_reload |=> $stable(str_a) && $stable(str_b);
  endproperty
  a_str_frozen: assert property (p_str_frozen) else $error("strength moved while low");

  property p_dyn_delay;
    sq_state_r == rgs_pkg::SQ_IDLE && sq_dyn_go && !cmd_wr
      |=> (sq_state_r == rgs_pkg::SQ_DELAY) [*8];
  endproperty
  a_dyn_delay: assert property (p_dyn_delay) else $error("dynamic squelch delay short");

  property p_agc_start;
    rx_rise && agc_en && !cmd_reload |=> agc_step_r == (agc_alg ? 4'h4 : 4'h0);
  endproperty
  a_agc_start: assert property (p_agc_start) else $error("gain loop bad start code");
endmodule : rgs_top

//--- tb/rgs_rx_model.sv
// Behavioural model of the receiver gain stages and the two digitizing comparators
`timescale 1ns/1ps
module rgs_rx_model (
  // Clock
  input wire logic clk,
  // Gain settings from the block
  input wire logic [2:0] dig_win,
  input wire logic [2:0] gain23_red,
  // Scenario signal levels, in 3 dB steps above full gain
  input wire logic [3:0] noise_lvl,
  input wire logic [3:0] agc_lvl,
  // Comparator outputs
  output logic dig_cmp,
  output logic agc_cmp
);
  logic [2:0] tick_r = 3'h0;
  logic [3:0] step;
  // Total reduction is window steps plus stage cuts
  assign step = {1'b0, dig_win} + {1'b0, gain23_red};
  // Comparators idle low until the signal first crosses a window
  initial
  begin
    dig_cmp = 1'b0;
    agc_cmp = 1'b0;
  end
  // Slow toggling keeps pipeline lag from adding a spurious step
  always @(posedge clk)
  begin
    tick_r <= tick_r + 3'h1;
    if (tick_r == 3'h0 && noise_lvl > step)
      dig_cmp <= ~dig_cmp;
    if (tick_r == 3'h0 && agc_lvl > step)
      agc_cmp <= ~agc_cmp;
  end
endmodule : rgs_rx_model

//--- tb/tb_rx_gain_squelch_rssi_control.sv
// Self-checking bench for the receiver gain, squelch and strength block
`timescale 1ns/1ps
module tb_rx_gain_squelch_rssi_control;
  localparam int SQW = 40;
  localparam int SQD = 12;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, rx_on, tx_end, mask_done, subc;
  logic dig_cmp, agc_cmp, clip_en;
  logic [1:0] htrans;
  logic [2:0] hsize, dig_win, g23;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [3:0] str_a, str_b, noise, agc_lvl, st;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  // Block under test with short squelch timing
  rgs_top #(.SQ_WIN_CYC(SQW), .SQ_DELAY_CYC(SQD)) i_dut (
    .SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .DIG_CMP(dig_cmp),
    .AGC_CMP(agc_cmp), .RX_ON(rx_on), .TX_END(tx_end), .MASK_RX_DONE(mask_done),
    .SUBC_PULSE(subc), .STR_LVL_A(str_a), .STR_LVL_B(str_b), .DIG_WIN(dig_win),
    .GAIN23_RED(g23), .CLIP_EN(clip_en));
  // Analog far side
  rgs_rx_model i_rx (.clk(clk), .dig_win(dig_win), .gain23_red(g23),
    .noise_lvl(noise), .agc_lvl(agc_lvl), .dig_cmp(dig_cmp), .agc_cmp(agc_cmp));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      $display("BAD %0t run timed out", $time);
      give_verdict();
    end
  end
  task give_verdict;
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // One single AHB-Lite transfer; held until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic cmd(input int b);
    wr(rgs_pkg::OFS_CMD, 32'h1 << b);
    wt(3);
  endtask : cmd
  // Poll squelch busy once per window, bounded
  task automatic wait_sq;
    for (int i = 0; i < 40; i++)
    begin
      wt(SQW);
      rd(rgs_pkg::OFS_GAIN_STATE);
      if (rdata[rgs_pkg::GST_SQ_BUSY] === 1'b0)
        break;
    end
  endtask : wait_sq
  // Main sequence
  initial
  begin
    {rst_n, hwrite, rx_on, tx_end, mask_done, subc} = 6'h0;
    hsel = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    {haddr, hwdata} = 64'h0;
    {str_a, str_b, noise, agc_lvl} = 16'h0;
    wt(3);
    rst_n <= 1'b1;
    wt(1);
    chk({24'h0, hresp, clip_en, dig_win, g23}, 32'h0);
    rd(rgs_pkg::OFS_RX_CFG2);
    chk(rdata, 32'h5);
    rd(8'h40);
    chk(rdata, 32'h0);
    wr(rgs_pkg::OFS_GAIN_STATE, 32'hff);
    rd(rgs_pkg::OFS_GAIN_STATE);
    chk(rdata, 32'h0);
    // Whole step ladder through the initial setting, one past the end
    for (int s = 0; s < 12; s++)
    begin
      st = (s > 10) ? 4'ha : 4'(s);
      wr(rgs_pkg::OFS_RX_CFG4, 32'(s));
      cmd(rgs_pkg::CMD_GAIN_RELOAD);
      chk({26'h0, dig_win, g23}, (st <= 4'h4) ? {26'h0, st[2:0], 3'h0} :
        {26'h0, 3'h4, 3'(st - 4'h4)});
      rd(rgs_pkg::OFS_GAIN_STATE);
      chk({28'h0, rdata[7:4]}, {28'h0, st});
    end
    wr(rgs_pkg::OFS_RX_CFG4, 32'h0);
    cmd(rgs_pkg::CMD_GAIN_RELOAD);
    wr(rgs_pkg::OFS_RX_CFG2, 32'h0);
    // Squelch command refused inside the receive window
    noise <= 4'h5;
    rx_on <= 1'b1;
    wt(2);
    cmd(rgs_pkg::CMD_SQUELCH);
    wt(4 * SQW);
    rd(rgs_pkg::OFS_GAIN_STATE);
    chk({28'h0, rdata[7:4]}, 32'h0);
    rx_on <= 1'b0;
    wt(2);
    cmd(rgs_pkg::CMD_SQUELCH);
    wait_sq();
    chk({28'h0, rdata[7:4]}, 32'h5);
    noise <= 4'hf;
    cmd(rgs_pkg::CMD_SQUELCH);
    wait_sq();
    chk({28'h0, rdata[7:4]}, 32'ha);
    chk({26'h0, dig_win, g23}, {26'h0, 3'h4, 3'h6});
    cmd(rgs_pkg::CMD_GAIN_RELOAD);
    rd(rgs_pkg::OFS_GAIN_STATE);
    chk({28'h0, rdata[7:4]}, 32'h0);
    // Dynamic squelch: one window runs, then mask expiry stops it
    wr(rgs_pkg::OFS_RX_CFG2, 32'h8);
    tx_end <= 1'b1;
    wt(1);
    tx_end <= 1'b0;
    wt(SQD + SQW + 20);
    mask_done <= 1'b1;
    wt(1);
    mask_done <= 1'b0;
    wt(3 * SQW);
    rd(rgs_pkg::OFS_GAIN_STATE);
    chk({23'h0, rdata[8:4]}, 32'h1);
    noise <= 4'h0;
    cmd(rgs_pkg::CMD_GAIN_RELOAD);
    // Both gain loop start codes, stored on window fall
    for (int a = 0; a < 2; a++)
    begin
      wr(rgs_pkg::OFS_RX_CFG2, 32'h1 | (a << 2));
      rx_on <= 1'b1;
      wt(4);
      rd(rgs_pkg::OFS_GAIN_STATE);
      chk({28'h0, rdata[7:4]}, a ? 32'h4 : 32'h0);
      rx_on <= 1'b0;
      wt(3);
      rd(rgs_pkg::OFS_GAIN_STATE);
      chk({24'h0, rdata[7:0]}, a ? 32'h4 : 32'h0);
    end
    // Gain loop convergence with the peak meter restarted by raises
    wr(rgs_pkg::OFS_RX_CFG2, 32'h5);
    {agc_lvl, str_a, str_b} <= 12'h7cf;
    rx_on <= 1'b1;
    wt(150);
    str_a <= 4'h5;
    agc_lvl <= 4'h9;
    wt(150);
    rd(rgs_pkg::OFS_STRENGTH);
    chk(rdata, 32'hd5);
    rx_on <= 1'b0;
    wt(2);
    str_a <= 4'hd;
    wt(20);
    rd(rgs_pkg::OFS_STRENGTH);
    chk(rdata, 32'hd5);
    rd(rgs_pkg::OFS_GAIN_STATE);
    chk({31'h0, rdata[3:0] >= 4'h9 && rdata[3:0] <= 4'ha}, 32'h1);
    cmd(rgs_pkg::CMD_STR_CLEAR);
    rd(rgs_pkg::OFS_STRENGTH);
    chk(rdata, 32'h0);
    // Gain loop limited to the first eight subcarrier pulses
    cmd(rgs_pkg::CMD_GAIN_RELOAD);
    wr(rgs_pkg::OFS_RX_CFG2, 32'h7);
    agc_lvl <= 4'ha;
    rx_on <= 1'b1;
    wt(1);
    // Eight pulses after the window edge use up the adjustment time
    subc <= 1'b1;
    wt(8);
    subc <= 1'b0;
    wt(150);
    rx_on <= 1'b0;
    wt(3);
    rd(rgs_pkg::OFS_GAIN_STATE);
    chk({31'h0, rdata[3:0] >= 4'h4 && rdata[3:0] < 4'h8}, 32'h1);
    agc_lvl <= 4'h0;
    wr(rgs_pkg::OFS_RX_CFG2, 32'h0);
    // Analog preset, first without and then with peer mode configured
    cmd(rgs_pkg::CMD_ANALOG_PRESET);
    chk({31'h0, clip_en}, 32'h0);
    wr(rgs_pkg::OFS_MODE, 32'h1);
    cmd(rgs_pkg::CMD_ANALOG_PRESET);
    wt(2);
    chk({25'h0, clip_en, dig_win, g23}, {25'h0, 1'b1, 3'h4, 3'h2});
    rd(rgs_pkg::OFS_RX_CFG3);
    chk(rdata, 32'h3);
    give_verdict();
  end
endmodule : tb_rx_gain_squelch_rssi_control
